/* rtl/jcpc_defs.vh */
// constants of the scan-port configuration host: register map, fields, timing
`ifndef JCPC_DEFS_VH
`define JCPC_DEFS_VH
// -------------------------------------------------------------
// register offsets (byte addresses, word aligned)
// -------------------------------------------------------------
`define JCPC_REG_CTRL 4'h0
`define JCPC_REG_STATUS 4'h4
`define JCPC_REG_SHIFT 4'h8
`define JCPC_REG_RESULT 4'hC
// -------------------------------------------------------------
// control fields
// -------------------------------------------------------------
`define JCPC_CTRL_CMD_LSB 0
`define JCPC_CTRL_CMD_MSB 2
`define JCPC_CTRL_LEN_LSB 8
`define JCPC_CTRL_LEN_MSB 13
`define JCPC_CTRL_GO 31
// command codes
`define JCPC_CMD_RESET 3'h0
`define JCPC_CMD_IR 3'h1
`define JCPC_CMD_DR 3'h2
`define JCPC_CMD_IDLE 3'h3
// -------------------------------------------------------------
// status fields
// -------------------------------------------------------------
`define JCPC_ST_BUSY 0
`define JCPC_ST_DONE_PIN 1
`define JCPC_ST_OK 2
`define JCPC_ST_FAIL 3
`define JCPC_ST_ORDER_ERR 4
// -------------------------------------------------------------
// instruction codes tracked for ordering (arbitrary values)
// -------------------------------------------------------------
`define JCPC_IR_DISENGAGE 10'h02_B0
`define JCPC_IR_CONFIG_IO 10'h00_D
`define JCPC_IR_ENGAGE 10'h02_B1
`define JCPC_IR_BYPASS 10'h03_FF
// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define JCPC_TCK_HALF 8'h05
`define JCPC_INIT_CLOCKS 16'h00_C8
`define JCPC_RESET_VAL 32'h0000_0000
`endif

/* rtl/jcpc_host.v */
// scan-port configuration host with Avalon-MM register slave
// -------------------------------------------------------------
// Functional notes
// - software bypasses all non-target devices first; host only shifts staged bits
// - host reads completion flag, high means success
// - host gives extra clocks after last bit
// - other instructions need disengage then io setup
// - host flags io setup sent without disengage; software issues both
// - host holds chain enable inputs low
// - chain enables grounded or configure in order
// - chain enable out left open or chained
// - scheme select driven, never floating
// - reconfiguration request held high
// -------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "jcpc_defs.vh"
module jcpc_host (
    input wire mclk, // 20 MHz system clock
    input wire sys_rst, // async reset, active high
    input wire [3:0] avs_address, // byte address
    input wire avs_read, // read strobe
    input wire avs_write, // write strobe
    input wire [31:0] avs_writedata, // write data
    output reg [31:0] avs_readdata, // read data
    output wire avs_waitrequest, // slave stall
    output wire tck, // test clock to chain
    output reg tms, // test mode select
    output reg tdi, // test data into chain
    input wire tdo, // test data from chain
    input wire config_complete, // completion flag pin of target
    output wire chain_enable_in_n, // chain enable of targets
    output wire [2:0] scheme_select, // scheme select straps
    output wire reconfig_request_n, // reconfiguration request
    output wire config_serial_clock, // unused serial clock, held low
    output wire chip_wide_clear_n, // chip clear, held inactive
    output wire chip_wide_output_enable // chip output enable, held high
);
    // -------------------------------------------------------------
    // state codes
    // -------------------------------------------------------------
    localparam S_IDLE = 3'h0; // waiting for go
    localparam S_HEAD = 3'h1; // walking tms header
    localparam S_SHIFT = 3'h2; // shifting bits
    localparam S_TAIL = 3'h3; // back to run-test/idle
    localparam S_INIT = 3'h4; // extra idle clocks
    // -------------------------------------------------------------
    // static board levels
    // -------------------------------------------------------------
    // chain enable out of each target is left open, never driven here
    assign chain_enable_in_n = 1'b0;
    assign scheme_select = 3'h0;
    assign reconfig_request_n = 1'b1;
    assign config_serial_clock = 1'b0; // driven, not floating
    assign chip_wide_clear_n = 1'b1;
    assign chip_wide_output_enable = 1'b1;
    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    reg [2:0] state; // sequencer state
    reg [2:0] cmd; // latched command
    reg [5:0] len; // bits minus one
    reg [5:0] bitn; // bit index in shift
    reg [3:0] hstep; // header/tail step
    reg [31:0] shreg; // outgoing / incoming word
    reg [31:0] result; // last captured word
    reg [15:0] initcnt; // init clocks left
    reg [9:0] last_ir; // last instruction shifted
    reg [9:0] ir_code; // instruction staged at go; shreg is overwritten by capture
    reg disengaged; // disengage sent, no engage or reset command since
    reg order_err; // sticky: io setup without disengage
    reg cfg_ok; // completion flag read high
    reg cfg_fail; // completion flag read low
    reg tdo_s1, tdo_s2; // tdo synchroniser
    reg done_s1, done_s2; // completion flag synchroniser
    wire rise, fall; // test clock edge pulses
    wire busy; // an operation is running
    wire go; // start request
    assign busy = (state != S_IDLE);
    assign go = avs_write & (avs_address == `JCPC_REG_CTRL) & avs_writedata[`JCPC_CTRL_GO];
    // writes during busy stall the bus; reads always pass
    assign avs_waitrequest = avs_write & busy;
    jcpc_tck_gen u_tck (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run(busy),
        .tck(tck),
        .rise(rise),
        .fall(fall)
    );
    // -------------------------------------------------------------
    // input synchronisers; first stage read only by the second
    // -------------------------------------------------------------
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tdo_s1 <= 1'b0;
            tdo_s2 <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
        end else begin
            tdo_s1 <= tdo;
            tdo_s2 <= tdo_s1;
            done_s1 <= config_complete;
            done_s2 <= done_s1;
        end
    end
    // header tms pattern per command, from run-test/idle
    function hdr_tms;
        input [2:0] c;
        input [3:0] s;
        begin
            case (c)
                `JCPC_CMD_IR: hdr_tms = (s < 4'h2); // 1,1,0,0 -> shift-ir
                `JCPC_CMD_DR: hdr_tms = (s == 4'h0); // 1,0,0 -> shift-dr
                default: hdr_tms = (s < 4'h5); // reset: five ones, then idle
            endcase
        end
    endfunction
    function [3:0] hdr_len;
        input [2:0] c;
        begin
            case (c)
                `JCPC_CMD_IR: hdr_len = 4'h4;
                `JCPC_CMD_DR: hdr_len = 4'h3;
                default: hdr_len = 4'h6; // five ones then a zero
            endcase
        end
    endfunction
    // -------------------------------------------------------------
    // sequencer: tms/tdi change on falling tck so the chain samples
    // stable levels on rising tck; tdo captured on rising tck
    // -------------------------------------------------------------
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            cmd <= `JCPC_CMD_RESET;
            len <= 6'h00;
            bitn <= 6'h00;
            hstep <= 4'h0;
            shreg <= `JCPC_RESET_VAL;
            result <= `JCPC_RESET_VAL;
            initcnt <= 16'h0000;
            last_ir <= `JCPC_IR_BYPASS;
            ir_code <= `JCPC_IR_BYPASS;
            disengaged <= 1'b0;
            order_err <= 1'b0;
            cfg_ok <= 1'b0;
            cfg_fail <= 1'b0;
            tms <= 1'b1;
            tdi <= 1'b1;
        end else begin
            case (state)
                S_IDLE: begin
                    if (go) begin
                        cmd <= avs_writedata[`JCPC_CTRL_CMD_MSB:`JCPC_CTRL_CMD_LSB];
                        len <= avs_writedata[`JCPC_CTRL_LEN_MSB:`JCPC_CTRL_LEN_LSB];
                        hstep <= 4'h0;
                        bitn <= 6'h00;
                        initcnt <= `JCPC_INIT_CLOCKS;
                        ir_code <= shreg[9:0]; // kept for ordering checks
                        tms <= hdr_tms(avs_writedata[`JCPC_CTRL_CMD_MSB:`JCPC_CTRL_CMD_LSB], 4'h0);
                        state <= (avs_writedata[`JCPC_CTRL_CMD_MSB:`JCPC_CTRL_CMD_LSB]
                                  == `JCPC_CMD_IDLE) ? S_INIT : S_HEAD;
                        if (avs_writedata[`JCPC_CTRL_CMD_MSB:`JCPC_CTRL_CMD_LSB]
                            == `JCPC_CMD_IDLE) begin
                            tms <= 1'b0;
                            cfg_ok <= 1'b0;
                            cfg_fail <= 1'b0;
                        end
                    end else if (avs_write && avs_address == `JCPC_REG_SHIFT) begin
                        // staged bits, lsb first; software fills bypass codes of others
                        shreg <= avs_writedata;
                    end
                end
                S_HEAD: begin
                    if (fall) begin
                        if (hstep == hdr_len(cmd) - 4'h1) begin
                            if (cmd == `JCPC_CMD_RESET) begin
                                tms <= 1'b0;
                                disengaged <= 1'b0;
                                state <= S_IDLE;
                            end else begin
                                tms <= (len == 6'h00);
                                tdi <= shreg[0]; // first bit on falling edge
                                state <= S_SHIFT;
                            end
                        end else begin
                            hstep <= hstep + 4'h1;
                            tms <= hdr_tms(cmd, hstep + 4'h1);
                        end
                    end
                end
                S_SHIFT: begin
                    if (rise) begin
                        // bypassed bits arrive delayed; software pads by chain position
                        shreg <= {tdo_s2, shreg[31:1]};
                    end
                    if (fall) begin
                        if (bitn == len) begin
                            tms <= 1'b1; // update, then idle
                            hstep <= 4'h0;
                            state <= S_TAIL;
                        end else begin
                            bitn <= bitn + 6'h01;
                            tdi <= shreg[0];
                            tms <= (bitn + 6'h01 == len);
                        end
                    end
                end
                S_TAIL: begin
                    if (fall) begin
                        tms <= 1'b0; // exit1 -> update -> idle
                        if (hstep == 4'h1) begin
                            state <= S_IDLE;
                            result <= shreg;
                            if (cmd == `JCPC_CMD_IR) begin
                                last_ir <= ir_code;
                                if (ir_code == `JCPC_IR_DISENGAGE)
                                    disengaged <= 1'b1;
                                else if (ir_code == `JCPC_IR_ENGAGE)
                                    disengaged <= 1'b0;
                                else if (ir_code == `JCPC_IR_CONFIG_IO && !disengaged)
                                    order_err <= 1'b1;
                            end
                        end else begin
                            hstep <= hstep + 4'h1;
                        end
                    end
                end
                S_INIT: begin
                    if (fall) begin
                        if (initcnt == 16'h0001) begin
                            state <= S_IDLE;
                            cfg_ok <= done_s2;
                            cfg_fail <= ~done_s2;
                        end
                        initcnt <= initcnt - 16'h0001;
                    end
                end
                default: state <= S_IDLE;
            endcase
            // software clears order error by writing a one; set wins
            if (avs_write && !busy && avs_address == `JCPC_REG_STATUS
                && avs_writedata[`JCPC_ST_ORDER_ERR] && !(state == S_TAIL && fall))
                order_err <= 1'b0;
        end
    end
    // -------------------------------------------------------------
    // read mux, combinational so reads never wait
    // -------------------------------------------------------------
    always @* begin
        case (avs_address)
            `JCPC_REG_CTRL: avs_readdata = {16'h0000, 2'b00, len, 5'h00, cmd};
            `JCPC_REG_STATUS: avs_readdata = {22'h00_0000, last_ir[4:0], order_err,
                                              cfg_fail, cfg_ok, done_s2, busy};
            `JCPC_REG_SHIFT: avs_readdata = shreg;
            `JCPC_REG_RESULT: avs_readdata = result;
            default: avs_readdata = 32'h0000_0000;
        endcase
    end
endmodule // jcpc_host
`default_nettype wire

/* rtl/jcpc_tck_gen.v */
// test clock divider: one pulse per rising and per falling test clock edge
`timescale 1ns/1ps
`default_nettype none
`include "jcpc_defs.vh"
module jcpc_tck_gen (
    input wire mclk, // system clock
    input wire sys_rst, // async reset, active high
    input wire run, // let the test clock toggle
    output reg tck, // test clock out
    output wire rise, // pulse: tck goes high on this edge
    output wire fall // pulse: tck goes low on this edge
);
    reg [7:0] div; // half period counter
    wire wrap; // half period elapsed
    assign wrap = (div == `JCPC_TCK_HALF - 8'h01);
    assign rise = run & wrap & ~tck;
    assign fall = run & wrap & tck;
    // -------------------------------------------------------------
    // divider; tck parks low so the far side sees no stray edges
    // -------------------------------------------------------------
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div <= 8'h00;
            tck <= 1'b0;
        end else if (!run) begin
            div <= 8'h00; // restart cleanly on the next operation
            tck <= 1'b0;
        end else if (wrap) begin
            div <= 8'h00;
            tck <= ~tck;
        end else begin
            div <= div + 8'h01;
        end
    end
endmodule // jcpc_tck_gen
`default_nettype wire

/* tb/jcpc_dev_model.sv */
// partner: target device behind the scan port
`timescale 1ns/1ps
`default_nettype none
`include "jcpc_defs.vh"
module jcpc_dev_model #(
    parameter [31:0] ID_CODE = 32'h1234_5679, // arbitrary identity value
    parameter [9:0] IR_IDCODE = 10'h006, // read identity
    parameter [9:0] IR_PROGRAM = 10'h002, // load stream
    parameter integer CFG_BITS = 32, // stream length
    parameter integer INIT_CLKS = 190 // init clocks after stream
) (
    input wire logic tck, // test clock
    input wire logic tms, // mode select
    input wire logic tdi, // data in
    output logic tdo, // data out
    output logic config_complete // completion pin
);
    // next scan state, one nibble per state
    localparam [63:0] NXT_HI = 64'h2FEF_CC02_8785_5920;
    localparam [63:0] NXT_LO = 64'h1BDD_BBA1_4664_4311;
    logic [3:0] st = 4'h0; // scan state
    logic [9:0] ir = IR_IDCODE; // instruction
    logic [9:0] ir_sh = 10'h000; // instruction shifter
    logic [31:0] dr = 32'h0000_0000; // data shifter
    logic engaged = 1'b1; // active controller running
    integer nbits = 0; // stream bits taken
    integer nidle = 0; // init clocks seen
    // user pins, status line, clear and oe are never driven
    initial tdo = 1'b0;
    initial config_complete = 1'b0;
    always @(posedge tck) begin // inputs taken on rising edge
        st <= tms ? NXT_HI[st*4 +: 4] : NXT_LO[st*4 +: 4];
        case (st)
            4'd0: ir <= IR_IDCODE;
            4'd1: if (nbits >= CFG_BITS && !config_complete) begin
                nidle <= nidle + 1;
                config_complete <= (nidle + 1 >= INIT_CLKS);
            end
            4'd3: dr <= (ir == IR_IDCODE) ? ID_CODE : 32'h0000_0000;
            4'd4: begin // other instructions leave the stream count alone
                if (ir == IR_IDCODE) dr <= {tdi, dr[31:1]};
                else dr[0] <= tdi; // one stage
                if (ir == IR_PROGRAM) nbits <= nbits + 1; // taken raw
            end
            4'd10: ir_sh <= 10'h001;
            4'd11: ir_sh <= {tdi, ir_sh[9:1]};
            4'd15: begin
                ir <= ir_sh;
                if (ir_sh == `JCPC_IR_DISENGAGE) engaged <= 1'b0;
                if (ir_sh == `JCPC_IR_ENGAGE) engaged <= 1'b1;
                // a new load, or io setup after disengage, drops the old one
                if (ir_sh == IR_PROGRAM || (ir_sh == `JCPC_IR_CONFIG_IO && !engaged)) begin
                    nbits <= 0;
                    nidle <= 0;
                    config_complete <= 1'b0;
                end
            end
            default: ;
        endcase
    end
    always @(negedge tck) begin // output moves on falling edge
        if (st == 4'd4) tdo <= dr[0];
        else if (st == 4'd11) tdo <= ir_sh[0];
        else tdo <= ~tdo; // released: no level held
    end
endmodule // jcpc_dev_model
`default_nettype wire

/* tb/jcpc_host_checker.sv */
// checker: scan host strap levels, test clock shape and bus timing
`timescale 1ns/1ps
`default_nettype none
`include "jcpc_defs.vh"
module jcpc_host_checker (
    input wire logic mclk, // clock
    input wire logic sys_rst, // reset
    input wire logic [3:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic tck, // test clock
    input wire logic tms, // mode
    input wire logic tdi, // data
    input wire logic config_complete, // pin
    input wire logic chain_enable_in_n, // strap
    input wire logic [2:0] scheme_select, // strap
    input wire logic reconfig_request_n, // strap
    input wire logic config_serial_clock, // unused serial clock
    input wire logic chip_wide_clear_n, // chip clear
    input wire logic chip_wide_output_enable // chip oe
);
    // ---------
    // properties
    // ---------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // each half of a test clock lasts five system clocks
    sequence s_hi; tck [*5]; endsequence
    sequence s_lo; (!tck) [*5]; endsequence
    property p_tck_high; $rose(tck) |-> s_hi ##1 !tck; endproperty
    a_tck_high: assert property (p_tck_high) else $error("tck high time wrong");
    property p_tck_low; $fell(tck) |-> s_lo; endproperty
    a_tck_low: assert property (p_tck_low) else $error("tck low time short");
    // mode and data may only move while the clock is low
    property p_pins_steady; tck && $past(tck) |-> $stable(tms) && $stable(tdi); endproperty
    a_pins_steady: assert property (p_pins_steady) else $error("tms or tdi moved");
    property p_straps; !chain_enable_in_n && scheme_select == 3'h0 && reconfig_request_n
        && !config_serial_clock;
    endproperty
    a_straps: assert property (p_straps) else $error("strap level wrong");
    property p_chip_pins; chip_wide_clear_n && chip_wide_output_enable; endproperty
    a_chip_pins: assert property (p_chip_pins) else $error("chip pin active");
    property p_read_nowait; avs_read |-> !avs_waitrequest; endproperty
    a_read_nowait: assert property (p_read_nowait) else $error("read stalled");
    property p_wait_write; avs_waitrequest |-> avs_write; endproperty
    a_wait_write: assert property (p_wait_write) else $error("idle stall");
    // the flag seen by software is the pin two clocks back
    property p_done_flag; avs_read && avs_address == `JCPC_REG_STATUS |->
        avs_readdata[`JCPC_ST_DONE_PIN] == $past(config_complete, 2); endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag wrong");
endmodule // jcpc_host_checker
`default_nettype wire

/* tb/jcpc_host_tb.sv */
// testbench: scan host driving a behavioural target device
`timescale 1ns/1ps
`default_nettype none
`include "jcpc_defs.vh"
module jcpc_host_tb;
    logic mclk = 1'b0; // system clock
    logic sys_rst = 1'b1; // reset
    logic [3:0] avs_address = 4'h0; // bus address
    logic avs_read = 1'b0; // read strobe
    logic avs_write = 1'b0; // write strobe
    logic [31:0] avs_writedata = 32'h0000_0000; // write data
    wire [31:0] avs_readdata; // read data
    wire avs_waitrequest, tck, tms, tdi, tdo, config_complete; // links
    integer n_mismatch = 0, num_checks = 0, seed = 32'h83f5, i; // counters, seed
    logic [31:0] rd, d; // bus result, random word
    localparam [9:0] IR_ID = 10'h006, IR_PRG = 10'h002; // arbitrary model codes
    localparam [31:0] ID = 32'h1234_5679; // arbitrary identity value
    always #25 mclk = ~mclk; // 50 ns period
    jcpc_host u_dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .config_complete(config_complete),
        .chain_enable_in_n(), .scheme_select(), .reconfig_request_n(),
        .config_serial_clock(), .chip_wide_clear_n(), .chip_wide_output_enable());
    jcpc_dev_model #(.ID_CODE(ID), .IR_IDCODE(IR_ID), .IR_PROGRAM(IR_PRG)) u_dev (.tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .config_complete(config_complete));
    task automatic chk(input [31:0] got, input [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch = n_mismatch + 1;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a wait that ran out ends the run
    task automatic guard(input hit);
        if (hit) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    endtask
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input w, input [3:0] a, input [31:0] wd, output [31:0] q);
        integer n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            n = n + 1;
        end while (avs_waitrequest !== 1'b0 && n < 5000);
        guard(avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // one scan operation; waits for idle and returns the captured word
    task automatic op(input [2:0] c, input [5:0] lm1, input [31:0] wd, output [31:0] res);
        integer n;
        bus(1'b1, `JCPC_REG_SHIFT, wd, res);
        bus(1'b1, `JCPC_REG_CTRL, {1'b1, 17'h0_0000, lm1, 5'h00, c}, res);
        n = 0;
        res = 32'h0000_0001;
        while (res[`JCPC_ST_BUSY] !== 1'b0 && n < 4000) begin
            bus(1'b0, `JCPC_REG_STATUS, 32'h0000_0000, res);
            n = n + 1;
        end
        guard(n >= 4000);
        bus(1'b0, `JCPC_REG_RESULT, 32'h0000_0000, res);
    endtask
    task automatic ir_op(input [9:0] code);
        op(`JCPC_CMD_IR, 6'h09, {22'h00_0000, code}, rd);
    endtask
    task automatic st_get(input [31:0] mask);
        bus(1'b0, `JCPC_REG_STATUS, 32'h0000_0000, rd);
        rd = rd & mask;
    endtask
    // a bypass stage returns its captured zero first, then the data
    function automatic [31:0] exp_byp(input [31:0] v);
        exp_byp = {v[30:0], 1'b0};
    endfunction
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
        for (i = 0; i < 5; i = i + 1) begin
            bus(1'b0, (i == 4) ? 4'h2 : {i[1:0], 2'b00}, 32'h0000_0000, rd);
            chk(rd, (i == 1) ? 32'h0000_03E0 : 32'h0000_0000);
        end
        $display("reset values done");
        op(`JCPC_CMD_RESET, 6'h05, 32'h0000_0000, rd);
        op(`JCPC_CMD_DR, 6'h1F, $random(seed), rd);
        chk(rd, ID);
        ir_op(`JCPC_IR_BYPASS);
        st_get(32'h0000_03E0);
        chk(rd, 32'h0000_03E0);
        for (i = 0; i < 3; i = i + 1) begin
            d = $random(seed);
            op(`JCPC_CMD_DR, 6'h1F, d, rd);
            chk(rd, exp_byp(d));
        end
        op(`JCPC_CMD_IDLE, 6'h00, 32'h0000_0000, rd);
        st_get(32'h0000_000E);
        chk(rd, 32'h0000_0008);
        $display("bypass and early check done");
        ir_op(IR_PRG);
        op(`JCPC_CMD_DR, 6'h1F, $random(seed), rd);
        for (i = 0; i < 3; i = i + 1) begin
            ir_op((i == 0) ? IR_ID : (i == 1) ? 10'h005 : `JCPC_IR_BYPASS);
            d = $random(seed);
            op(`JCPC_CMD_DR, 6'h1F, d, rd);
            chk(rd, (i == 0) ? ID : exp_byp(d));
        end
        op(`JCPC_CMD_IDLE, 6'h00, 32'h0000_0000, rd);
        st_get(32'h0000_000E);
        chk(rd, 32'h0000_0006);
        $display("configuration done");
        ir_op(`JCPC_IR_CONFIG_IO);
        st_get(32'h0000_0010);
        chk(rd, 32'h0000_0010);
        bus(1'b1, `JCPC_REG_STATUS, 32'h0000_0010, rd);
        st_get(32'h0000_0010);
        chk(rd, 32'h0000_0000);
        ir_op(`JCPC_IR_DISENGAGE);
        ir_op(`JCPC_IR_CONFIG_IO);
        st_get(32'h0000_0010);
        chk(rd, 32'h0000_0000);
        op(`JCPC_CMD_IDLE, 6'h00, 32'h0000_0000, rd);
        st_get(32'h0000_000E);
        chk(rd, 32'h0000_0008);
        ir_op(`JCPC_IR_ENGAGE);
        $display("interrupt flow done");
        close_out;
    end
endmodule // jcpc_host_tb
bind jcpc_host jcpc_host_checker u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tck(tck), .tms(tms),
    .tdi(tdi), .config_complete(config_complete), .chain_enable_in_n(chain_enable_in_n),
    .scheme_select(scheme_select), .reconfig_request_n(reconfig_request_n),
    .config_serial_clock(config_serial_clock),
    .chip_wide_clear_n(chip_wide_clear_n), .chip_wide_output_enable(chip_wide_output_enable));
`default_nettype wire
